// file: inc/wdcs_pkg.sv
// shared constants and types of the watchdog control and status block
package wdcs_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int WDT_HZ = 1000;
  localparam int TICK_CYCLES = CLK_HZ / WDT_HZ;
  localparam int SYNC_TICKS = 3;
  localparam int UNLOCK_CYCLES = 4;
  localparam int CNT_W = 14;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_EVT_STAT = 4'h2;
  localparam logic [3:0] OFS_EVT_CLR = 4'h3;
  localparam logic [3:0] OFS_EVT_EN = 4'h4;
  localparam int LOCK_BIT = 7;
  localparam int BUSY_BIT = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [3:0] EVT_RST = 4'h0;
  localparam logic [3:0] CODE_OFF = 4'h0;
  localparam logic [3:0] CODE_MAX = 4'hB;
  // ----------------------------------------
  // events
  // ----------------------------------------
  localparam int EVT_W = 4;
  localparam int EVT_TIMEOUT = 0;
  localparam int EVT_EARLY = 1;
  localparam int EVT_DROP = 2;
  localparam int EVT_SYNC = 3;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] window;
    logic [3:0] period;
  } wdcs_ctrl_t;
  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_FIRST = 4'b0010,
    ST_CLOSED = 4'b0100,
    ST_OPEN = 4'b1000
  } wdcs_state_t;
  // reserved codes saturate at the longest length
  function automatic logic [CNT_W-1:0] wdcs_len(input logic [3:0] code);
    logic [3:0] c;
    c = (code > CODE_MAX) ? CODE_MAX : code;
    wdcs_len = CNT_W'(14'h0008 << (c - 4'h1));
  endfunction : wdcs_len
endpackage : wdcs_pkg

// file: rtl/wdcs_tick_div.sv
// divider making the slow watchdog tick enable
module wdcs_tick_div #(
  parameter int DIV = wdcs_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  output logic tick
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic tick_nxt;

  always_comb begin
    tick_nxt = (cnt_r == 32'(DIV - 1));
    cnt_nxt = tick_nxt ? 32'h0 : cnt_r + 32'h1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r <= 32'h0;
      tick <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick <= tick_nxt;
    end
  end
endmodule : wdcs_tick_div

// file: rtl/wdcs_tick_sync.sv
// models a crossing into the slow domain: busy for a number of ticks
module wdcs_tick_sync #(
  parameter int TICKS = wdcs_pkg::SYNC_TICKS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic busy_nxt;
  logic done_nxt;

  // start while busy is ignored; the caller sees busy
  always_comb begin
    cnt_nxt = cnt_r;
    busy_nxt = busy;
    done_nxt = 1'b0;
    if (!busy && start) begin
      busy_nxt = 1'b1;
      cnt_nxt = 4'h0;
    end else if (busy && tick) begin
      cnt_nxt = cnt_r + 4'h1;
      if (cnt_r == 4'(TICKS - 1)) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r <= 4'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      busy <= busy_nxt;
      done <= done_nxt;
    end
  end
endmodule : wdcs_tick_sync

// file: rtl/wdcs_top.sv
// watchdog control and status registers with the watchdog timer itself
// What this block does
// (RL1) high control nibble nonzero enables window mode; codes 1..B give 8..8K closed ticks
// (RL2) low control nibble nonzero enables watchdog; codes 1..B give 8..8K timeout
// (RL3) lock set makes control read-only, so watchdog cannot be disabled
// (RL4) lock may be set by software or at boot (RL5); cleared only in debug mode
// (RL5) nonzero period after boot sets lock automatically
// (RL6) busy flag set on control write, clears once value reaches slow domain
// (RL7) lock and control writes need the unlock sequence just before
// (RL8) busy flag is read-only and readable without unlock
// (RL9) control at offset 0, status at offset 1, status resets to zero
// (RL10) software writes the key then the protected bit within four instructions
// (RL11) software does not write control while busy reads one
// (RL12) refresh in closed window or no refresh in time issues system reset
// (RL13) refresh takes two to three ticks to sync; another meanwhile is ignored
// (RL14) durations count slow ticks, restarting on each accepted refresh
//
// The implementer's own choice: the strobed register port.
module wdcs_top #(
  parameter int TICK_DIV = wdcs_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic protected_write_unlock,
  input wire logic watchdog_refresh,
  input wire logic debug_mode,
  input wire logic boot_done,
  input wire logic [7:0] boot_config_fuse,
  output logic sys_reset_req,
  output logic irq
);
  // ----------------------------------------
  // slow tick and crossings
  // ----------------------------------------
  logic tick;
  logic csync_start;
  logic csync_busy;
  logic csync_done;
  logic rsync_start;
  logic rsync_busy;
  logic rsync_done;

  wdcs_tick_div #(.DIV(TICK_DIV)) u_div (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick)
  );

  wdcs_tick_sync #(.TICKS(wdcs_pkg::SYNC_TICKS)) u_csync (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick),
    .start(csync_start),
    .busy(csync_busy),
    .done(csync_done)
  );

  wdcs_tick_sync #(.TICKS(wdcs_pkg::SYNC_TICKS)) u_rsync (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick),
    .start(rsync_start),
    .busy(rsync_busy),
    .done(rsync_done)
  );

  // ----------------------------------------
  // register group
  // ----------------------------------------
  wdcs_pkg::wdcs_ctrl_t ctrl_r, ctrl_nxt;
  wdcs_pkg::wdcs_ctrl_t act_r, act_nxt;
  logic lock_r, lock_nxt;
  logic [2:0] unl_r, unl_nxt;
  logic [3:0] evt_r, evt_nxt;
  logic [3:0] en_r, en_nxt;
  logic [7:0] rdata_nxt;
  logic irq_nxt;
  logic [7:0] status;
  logic unlocked;
  logic wr_ctrl_ok;
  logic [3:0] evt_set;
  logic boot_r;

  assign unlocked = (unl_r != 3'h0);
  assign status = {lock_r, 6'h00, csync_busy}; // RL8 RL9
  // writes during busy would be lost in the crossing, so they are dropped
  assign wr_ctrl_ok = wr_en && addr == wdcs_pkg::OFS_CTRL && unlocked
                      && !lock_r && !csync_busy; // RL3 RL7 RL11
  assign csync_start = wr_ctrl_ok; // RL6

  always_comb begin
    ctrl_nxt = ctrl_r;
    act_nxt = act_r;
    lock_nxt = lock_r;
    en_nxt = en_r;
    evt_nxt = evt_r;
    rdata_nxt = 8'h00;
    unl_nxt = (unl_r != 3'h0) ? unl_r - 3'h1 : 3'h0;
    if (protected_write_unlock) begin
      unl_nxt = 3'(wdcs_pkg::UNLOCK_CYCLES);
    end
    if (boot_done && !boot_r) begin
      ctrl_nxt = boot_config_fuse;
      act_nxt = boot_config_fuse;
      if (boot_config_fuse[3:0] != wdcs_pkg::CODE_OFF) begin
        lock_nxt = 1'b1; // RL5
      end
    end else if (wr_ctrl_ok) begin
      ctrl_nxt = wdata; // RL1 RL2
    end
    if (csync_done) begin
      act_nxt = ctrl_r; // RL6
    end
    if (wr_en && addr == wdcs_pkg::OFS_STATUS && unlocked) begin // RL7
      if (wdata[wdcs_pkg::LOCK_BIT]) begin
        lock_nxt = 1'b1; // RL4
      end else if (debug_mode) begin
        lock_nxt = 1'b0; // RL4
      end
    end
    if (wr_en && addr == wdcs_pkg::OFS_EVT_EN) begin
      en_nxt = wdata[3:0];
    end
    // a new event wins over a clear in the same cycle
    if (wr_en && addr == wdcs_pkg::OFS_EVT_CLR) begin
      evt_nxt = evt_r & ~wdata[3:0];
    end
    evt_nxt = evt_nxt | evt_set;
    if (rd_en) begin
      if (addr == wdcs_pkg::OFS_CTRL) begin
        rdata_nxt = ctrl_r; // RL9
      end else if (addr == wdcs_pkg::OFS_STATUS) begin
        rdata_nxt = status; // RL8
      end else if (addr == wdcs_pkg::OFS_EVT_STAT) begin
        rdata_nxt = {4'h0, evt_r};
      end else if (addr == wdcs_pkg::OFS_EVT_EN) begin
        rdata_nxt = {4'h0, en_r};
      end else begin
        rdata_nxt = 8'h00;
      end
    end
    irq_nxt = |(evt_nxt & en_nxt);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_r <= wdcs_pkg::CTRL_RST;
      act_r <= wdcs_pkg::CTRL_RST;
      lock_r <= wdcs_pkg::STATUS_RST[wdcs_pkg::LOCK_BIT]; // RL9
      unl_r <= 3'h0;
      evt_r <= wdcs_pkg::EVT_RST;
      en_r <= wdcs_pkg::EVT_RST;
      rdata <= 8'h00;
      irq <= 1'b0;
      boot_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      act_r <= act_nxt;
      lock_r <= lock_nxt;
      unl_r <= unl_nxt;
      evt_r <= evt_nxt;
      en_r <= en_nxt;
      rdata <= rdata_nxt;
      irq <= irq_nxt;
      boot_r <= boot_r | boot_done;
    end
  end

  // ----------------------------------------
  // watchdog group
  // ----------------------------------------
  wdcs_pkg::wdcs_state_t st_r, st_nxt;
  logic [wdcs_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [wdcs_pkg::CNT_W-1:0] cnt_inc;
  logic rst_req_nxt;
  logic win_on;

  assign win_on = (act_r.window != wdcs_pkg::CODE_OFF); // RL1
  assign cnt_inc = cnt_r + 14'h0001;
  assign rsync_start = watchdog_refresh && st_r != wdcs_pkg::ST_OFF; // RL13
  assign evt_set = {csync_done, watchdog_refresh && rsync_busy, // RL13
                    st_r == wdcs_pkg::ST_CLOSED && rsync_done, rst_req_nxt};

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    rst_req_nxt = 1'b0;
    if (act_r.period == wdcs_pkg::CODE_OFF) begin
      st_nxt = wdcs_pkg::ST_OFF; // RL2
      cnt_nxt = 14'h0000;
    end else if (debug_mode) begin
      // halted cpu: counter cleared, closed window skipped after resume
      st_nxt = wdcs_pkg::ST_FIRST;
      cnt_nxt = 14'h0000;
    end else begin
      case (st_r)
        wdcs_pkg::ST_OFF: begin
          st_nxt = wdcs_pkg::ST_FIRST; // RL2
          cnt_nxt = 14'h0000;
        end
        wdcs_pkg::ST_CLOSED: begin
          if (rsync_done) begin
            rst_req_nxt = 1'b1; // RL12
            st_nxt = wdcs_pkg::ST_FIRST;
            cnt_nxt = 14'h0000;
          end else if (tick) begin
            cnt_nxt = cnt_inc; // RL14
            if (cnt_inc == wdcs_pkg::wdcs_len(act_r.window)) begin // RL1
              st_nxt = wdcs_pkg::ST_OPEN;
              cnt_nxt = 14'h0000;
            end
          end
        end
        default: begin
          if (rsync_done) begin
            st_nxt = win_on ? wdcs_pkg::ST_CLOSED : wdcs_pkg::ST_FIRST; // RL1
            cnt_nxt = 14'h0000; // RL14
          end else if (tick) begin
            cnt_nxt = cnt_inc; // RL14
            if (cnt_inc == wdcs_pkg::wdcs_len(act_r.period)) begin // RL2
              rst_req_nxt = 1'b1; // RL12
              st_nxt = wdcs_pkg::ST_FIRST;
              cnt_nxt = 14'h0000;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= wdcs_pkg::ST_OFF;
      cnt_r <= 14'h0000;
      sys_reset_req <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sys_reset_req <= rst_req_nxt;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_lock_sticky;
    lock_r && !debug_mode |=> lock_r;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared outside debug"); // RL4

  property p_ctrl_locked;
    lock_r && !boot_done |=> $stable(ctrl_r);
  endproperty
  a_ctrl_locked: assert property (p_ctrl_locked) else $error("control changed while locked"); // RL3

  property p_lock_prot;
    !unlocked && !(boot_done && !boot_r) |=> $stable(lock_r);
  endproperty
  a_lock_prot: assert property (p_lock_prot) else $error("lock changed without unlock"); // RL7

  property p_busy_span;
    wr_ctrl_ok |=> csync_busy;
  endproperty
  a_busy_span: assert property (p_busy_span) else $error("busy not set by control write"); // RL6

  // busy may only end on a slow tick, once the new value sits on the slow side
  property p_busy_hold;
    csync_busy && !tick |=> csync_busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped between ticks"); // RL6

  property p_boot_lock;
    boot_done && !boot_r && boot_config_fuse[3:0] != 4'h0 |=> lock_r;
  endproperty
  a_boot_lock: assert property (p_boot_lock) else $error("boot did not lock"); // RL5

  property p_status_read;
    rd_en && addr == wdcs_pkg::OFS_STATUS |=> rdata == $past(status);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong"); // RL8

  property p_early_reset;
    st_r == wdcs_pkg::ST_CLOSED && rsync_done && !debug_mode && act_r.period != 4'h0 |=> sys_reset_req;
  endproperty
  a_early_reset: assert property (p_early_reset) else $error("closed-window refresh missed"); // RL12

  property p_drop;
    watchdog_refresh && rsync_busy |=> evt_r[wdcs_pkg::EVT_DROP];
  endproperty
  a_drop: assert property (p_drop) else $error("dropped refresh not flagged"); // RL13

  property p_off;
    act_r.period == 4'h0 |=> st_r == wdcs_pkg::ST_OFF && !sys_reset_req;
  endproperty
  a_off: assert property (p_off) else $error("disabled watchdog running"); // RL2

  c_timeout: cover property (sys_reset_req && st_r == wdcs_pkg::ST_FIRST);
  c_open: cover property (st_r == wdcs_pkg::ST_OPEN && rsync_done);
  c_lock_clear: cover property (lock_r ##1 !lock_r);
endmodule : wdcs_top

// file: verification/tb_wdcs_top.sv
// self-checking bench for the watchdog control and status block
module tb_wdcs_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int DIV = 10; // short tick so long counts stay cheap
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rdata;
  logic unl = 1'b0;
  logic refr = 1'b0;
  logic dbg = 1'b0;
  logic boot = 1'b0;
  logic [7:0] fuse = 8'h00;
  logic sr;
  logic irq;
  int miscompares = 0;
  int n_checks = 0;
  int sr_cnt = 0;
  int n;
  logic [7:0] v;
  // only a nonzero period may lock at boot
  logic [7:0] fuse_vals [2] = '{8'h20, 8'h02};
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (sr === 1'b1) sr_cnt <= sr_cnt + 1;
  wdcs_top #(.TICK_DIV(DIV)) dut_u (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .protected_write_unlock(unl), .watchdog_refresh(refr), .debug_mode(dbg),
    .boot_done(boot), .boot_config_fuse(fuse), .sys_reset_req(sr), .irq(irq)
  );
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // optional key pulse lands two edges before the write
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input bit p);
    if (p) begin
      @(posedge core_clk) unl <= 1'b1;
      @(posedge core_clk) unl <= 1'b0;
    end
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk) wr_en <= 1'b0;
  endtask : wr
  task automatic rdv(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk) rd_en <= 1'b0;
    @(negedge core_clk) d = rdata;
  endtask : rdv
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rdv(a, d);
    chk(d, exp);
  endtask : rd
  task automatic wait_busy;
    logic [7:0] d;
    int i;
    for (i = 0; i < 100; i++) begin
      rdv(wdcs_pkg::OFS_STATUS, d);
      if (d[0] === 1'b0) break;
    end
    if (i == 100) begin
      miscompares++;
      stop_test();
    end
  endtask : wait_busy
  task automatic wait_sr(input int lim, output int cnt);
    int c0;
    c0 = sr_cnt;
    cnt = 0;
    while (sr_cnt == c0 && cnt < lim) begin
      @(negedge core_clk);
      cnt++;
    end
    if (sr_cnt == c0) begin
      miscompares++;
      stop_test();
    end
  endtask : wait_sr
  task automatic rfr;
    @(posedge core_clk) refr <= 1'b1;
    @(posedge core_clk) refr <= 1'b0;
  endtask : rfr
  task automatic cirq(input logic e);
    @(posedge core_clk);
    @(negedge core_clk) chk({7'h00, irq}, {7'h00, e});
  endtask : cirq
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rd(wdcs_pkg::OFS_STATUS, 8'h00);
    rd(wdcs_pkg::OFS_CTRL, 8'h00);
    rd(4'hF, 8'h00);
    wr(wdcs_pkg::OFS_CTRL, 8'h21, 0);
    rd(wdcs_pkg::OFS_CTRL, 8'h00);
    $display("test reset and unprotected write done");
    wr(wdcs_pkg::OFS_EVT_EN, 8'h08, 0);
    for (int w = 0; w < 12; w++) begin
      wr(wdcs_pkg::OFS_CTRL, {w[3:0], 4'h0}, 1);
      rd(wdcs_pkg::OFS_STATUS, 8'h01);
      wr(wdcs_pkg::OFS_CTRL, 8'hF0, 1);
      wait_busy();
      rd(wdcs_pkg::OFS_CTRL, {w[3:0], 4'h0});
    end
    cirq(1'b1);
    wr(wdcs_pkg::OFS_EVT_EN, 8'h00, 0);
    cirq(1'b0);
    wr(wdcs_pkg::OFS_EVT_EN, 8'h08, 0);
    cirq(1'b1);
    rd(wdcs_pkg::OFS_EVT_EN, 8'h08);
    wr(wdcs_pkg::OFS_EVT_CLR, 8'h08, 0);
    cirq(1'b0);
    rd(wdcs_pkg::OFS_EVT_STAT, 8'h00);
    $display("test window codes, busy flag and interrupt done");
    wr(wdcs_pkg::OFS_CTRL, 8'h01, 1);
    wait_busy();
    wait_sr(200, n);
    chk({7'h00, n >= 60 && n <= 90}, 8'h01);
    n = sr_cnt;
    repeat (6) begin
      rfr();
      repeat (40) @(posedge core_clk);
    end
    chk(8'(sr_cnt - n), 8'h00);
    $display("test timeout and refresh done");
    wr(wdcs_pkg::OFS_STATUS, 8'h80, 0);
    rd(wdcs_pkg::OFS_STATUS, 8'h00);
    wr(wdcs_pkg::OFS_STATUS, 8'h80, 1);
    rd(wdcs_pkg::OFS_STATUS, 8'h80);
    wr(wdcs_pkg::OFS_CTRL, 8'h00, 1);
    rd(wdcs_pkg::OFS_CTRL, 8'h01);
    wr(wdcs_pkg::OFS_STATUS, 8'h00, 1);
    rd(wdcs_pkg::OFS_STATUS, 8'h80);
    @(posedge core_clk) dbg <= 1'b1;
    wr(wdcs_pkg::OFS_STATUS, 8'h00, 1);
    rd(wdcs_pkg::OFS_STATUS, 8'h00);
    @(posedge core_clk) dbg <= 1'b0;
    $display("test lock done");
    wr(wdcs_pkg::OFS_CTRL, 8'h11, 1);
    wait_busy();
    wr(wdcs_pkg::OFS_EVT_CLR, 8'h0F, 0);
    rfr();
    rfr();
    repeat (40) @(posedge core_clk);
    rfr();
    wait_sr(80, n);
    chk({7'h00, n <= 50}, 8'h01);
    rdv(wdcs_pkg::OFS_EVT_STAT, v);
    chk(v & 8'h06, 8'h06);
    $display("test closed window and dropped refresh done");
    foreach (fuse_vals[i]) begin
      @(posedge core_clk) rst <= 1'b1;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      fuse <= fuse_vals[i];
      boot <= 1'b1;
      @(posedge core_clk) boot <= 1'b0;
      rd(wdcs_pkg::OFS_CTRL, fuse_vals[i]);
      rd(wdcs_pkg::OFS_STATUS, (fuse_vals[i][3:0] != 4'h0) ? 8'h80 : 8'h00);
    end
    $display("test boot load done");
    stop_test();
  end
endmodule : tb_wdcs_top
